/* hw/pfm_pkg.sv */
/*
 * pfm_pkg: constants shared by the pin function block.
 * assumes: pins are flattened low to high as AD, E, J, M, P, S, T.
 */
package pfm_pkg;
    // pin counts and offsets into the flattened pin vector
    localparam int NAD = 10;
    localparam int NP8 = 8;
    localparam int NS = 4;
    localparam int OFF_AD = 0;
    localparam int OFF_E = 10;
    localparam int OFF_J = 18;
    localparam int OFF_M = 26;
    localparam int OFF_P = 34;
    localparam int OFF_S = 42;
    localparam int OFF_T = 46;
    localparam int NPIN = 54;
    // bit positions inside each port, then modulator and timer channel counts
    localparam int E_DBLCLK = 7;
    localparam int E_BUSCLK = 4;
    localparam int E_IRQ = 1;
    localparam int E_NMI = 0;
    localparam int M_SCK = 5;
    localparam int M_MOSI = 4;
    localparam int M_SS = 3;
    localparam int M_MISO = 2;
    localparam int M_CANTX = 1;
    localparam int M_CANRX = 0;
    localparam int S_TX = 1;
    localparam int S_RX = 0;
    localparam int T_API = 5;
    localparam int NPWM = 6;
    localparam int NTIM = 8;
    // pins that may act as keypad wakeup inputs
    localparam logic [7:0] KEY_J_MASK = 8'hc7;
    localparam logic [7:0] KEY_P_MASK = 8'hbf;
    // port T pins that also carry a modulator output
    localparam logic [7:0] T_PWM_MASK = 8'h31;
    // reset values and the normal mode value
    localparam logic MODE_RESET = 1'h1;
    localparam logic MODE_NORMAL = 1'h1;
    localparam logic CLK_INTERNAL = 1'h0;
    localparam logic [3:0] PRESCALE_RESET = 4'h1;
    typedef enum logic [1:0] {
        TSEL_GPIO = 2'b00,
        TSEL_TIMER = 2'b01,
        TSEL_PWM = 2'b10,
        TSEL_API = 2'b11
    } pfm_tsel_e;
endpackage

/* hw/pfm_pin_mux.sv */
/*
 * pfm_pin_mux: pin function logic of a small microcontroller; port muxing,
 * reset pin, mode capture, debug line, interrupt pins and keypad wakeup.
 * assumes: the core supplies general-purpose port settings and peripheral
 * signals on ref_clk; pin wires are resolved from the enables outside.
 */
`timescale 1ns/100ps
module pfm_pin_mux #(
    parameter int PW = 4
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic int_reset_req,
    output logic chip_reset_n,
    input wire logic debug_line_in,
    output logic debug_line_out,
    output logic debug_line_oe,
    output logic debug_pullup_en,
    input wire logic bdm_drive_low,
    output logic mode_capture_bit,
    output logic bdm_active,
    input wire logic osc_select,
    output logic clk_source_osc,
    input wire logic [pfm_pkg::NAD-1:0] ad_pin_in,
    output logic [pfm_pkg::NAD-1:0] ad_pin_out,
    output logic [pfm_pkg::NAD-1:0] ad_pin_oe,
    input wire logic [pfm_pkg::NAD-1:0] ad_gpio_out,
    input wire logic [pfm_pkg::NAD-1:0] ad_gpio_oe,
    output logic [pfm_pkg::NAD-1:0] ad_gpio_in,
    output logic [pfm_pkg::NAD-1:0] converter_analog_inputs,
    input wire logic [pfm_pkg::NP8-1:0] e_pin_in,
    output logic [pfm_pkg::NP8-1:0] e_pin_out,
    output logic [pfm_pkg::NP8-1:0] e_pin_oe,
    input wire logic [pfm_pkg::NP8-1:0] e_gpio_out,
    input wire logic [pfm_pkg::NP8-1:0] e_gpio_oe,
    output logic [pfm_pkg::NP8-1:0] e_gpio_in,
    input wire logic port_e_bit7_pullup_req,
    output logic port_e_pullup_en,
    input wire logic [pfm_pkg::NP8-1:0] j_pin_in,
    output logic [pfm_pkg::NP8-1:0] j_pin_out,
    output logic [pfm_pkg::NP8-1:0] j_pin_oe,
    input wire logic [pfm_pkg::NP8-1:0] j_gpio_out,
    input wire logic [pfm_pkg::NP8-1:0] j_gpio_oe,
    output logic [pfm_pkg::NP8-1:0] j_gpio_in,
    input wire logic [pfm_pkg::NP8-1:0] m_pin_in,
    output logic [pfm_pkg::NP8-1:0] m_pin_out,
    output logic [pfm_pkg::NP8-1:0] m_pin_oe,
    input wire logic [pfm_pkg::NP8-1:0] m_gpio_out,
    input wire logic [pfm_pkg::NP8-1:0] m_gpio_oe,
    output logic [pfm_pkg::NP8-1:0] m_gpio_in,
    input wire logic [pfm_pkg::NP8-1:0] p_pin_in,
    output logic [pfm_pkg::NP8-1:0] p_pin_out,
    output logic [pfm_pkg::NP8-1:0] p_pin_oe,
    input wire logic [pfm_pkg::NP8-1:0] p_gpio_out,
    input wire logic [pfm_pkg::NP8-1:0] p_gpio_oe,
    output logic [pfm_pkg::NP8-1:0] p_gpio_in,
    input wire logic [pfm_pkg::NS-1:0] s_pin_in,
    output logic [pfm_pkg::NS-1:0] s_pin_out,
    output logic [pfm_pkg::NS-1:0] s_pin_oe,
    input wire logic [pfm_pkg::NS-1:0] s_gpio_out,
    input wire logic [pfm_pkg::NS-1:0] s_gpio_oe,
    output logic [pfm_pkg::NS-1:0] s_gpio_in,
    input wire logic [pfm_pkg::NP8-1:0] t_pin_in,
    output logic [pfm_pkg::NP8-1:0] t_pin_out,
    output logic [pfm_pkg::NP8-1:0] t_pin_oe,
    input wire logic [pfm_pkg::NP8-1:0] t_gpio_out,
    input wire logic [pfm_pkg::NP8-1:0] t_gpio_oe,
    output logic [pfm_pkg::NP8-1:0] t_gpio_in,
    input wire logic bus_clk_en,
    input wire logic dbl_clk_en,
    input wire logic [PW-1:0] bus_clk_prescale,
    output logic bus_clock_out,
    output logic double_bus_clock_out,
    input wire logic irq_enable,
    input wire logic stop_request,
    input wire logic stop_active,
    input wire logic wait_active,
    output logic irq_request,
    output logic nmi_request,
    output logic stop_enter_ok,
    output logic wake_pulse,
    input wire logic [pfm_pkg::NP8-1:0] keypad_j_enable,
    input wire logic [pfm_pkg::NP8-1:0] keypad_p_enable,
    output logic [pfm_pkg::NP8-1:0] keypad_wake_j,
    output logic [pfm_pkg::NP8-1:0] keypad_wake_p,
    input wire logic spi_en,
    input wire logic spi_master,
    input wire logic spi_ss_out_en,
    input wire logic spi_sck_out,
    input wire logic spi_mosi_out,
    input wire logic spi_miso_out,
    input wire logic spi_ss_out,
    output logic spi_sck_in,
    output logic spi_mosi_in,
    output logic spi_miso_in,
    output logic spi_ss_in,
    input wire logic can_en,
    input wire logic can_tx_pin,
    output logic can_rx_pin,
    input wire logic serial_en,
    input wire logic serial_tx,
    output logic serial_rx,
    input wire logic [pfm_pkg::NPWM-1:0] pwm_p_en,
    input wire logic [pfm_pkg::NPWM-1:0] pwm_out,
    input wire logic [2*pfm_pkg::NTIM-1:0] t_sel,
    input wire logic [pfm_pkg::NTIM-1:0] timer_out,
    input wire logic [pfm_pkg::NTIM-1:0] timer_oe,
    output logic [pfm_pkg::NTIM-1:0] timer_in,
    input wire logic periodic_int_ext_clock
);
    import pfm_pkg::*;

    initial begin
        if (PW < 1 || PW > 16) begin
            $error("pfm_pin_mux: PW must lie in 1..16");
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    logic [NPIN-1:0] raw_in, gpio_out_flat, gpio_oe_flat;
    logic [NPIN-1:0] p_en, p_out, p_oe;
    logic [NPIN-1:0] next_pin_out, next_pin_oe, pin_out, pin_oe;
    logic [NPIN-1:0] s1, s2, next_s1, next_s2;
    logic rst_s1, rst_s2, dbg_s1, dbg_s2, rst_prev;
    logic next_rst_s1, next_rst_s2, next_dbg_s1, next_dbg_s2, next_rst_prev;
    logic next_mode, next_chip_rst_n, next_rst_drive, next_osc, next_pullup;
    logic rst_drive;
    logic [PW-1:0] cnt, next_cnt;
    logic bus_clk, dbl_clk, next_bus_clk, next_dbl_clk;
    logic [NP8-1:0] kj_prev, kp_prev, next_kj_prev, next_kp_prev;
    logic [NP8-1:0] next_kw_j, next_kw_p;
    logic next_wake;

    assign raw_in = {t_pin_in, s_pin_in, p_pin_in, m_pin_in, j_pin_in, e_pin_in, ad_pin_in};
    assign gpio_out_flat = {t_gpio_out, s_gpio_out, p_gpio_out, m_gpio_out, j_gpio_out,
                            e_gpio_out, ad_gpio_out};
    assign gpio_oe_flat = {t_gpio_oe, s_gpio_oe, p_gpio_oe, m_gpio_oe, j_gpio_oe,
                           e_gpio_oe, ad_gpio_oe};

    // two-stage synchronisers; only s2 is read by logic
    always_comb begin
        next_s1 = raw_in;
        next_s2 = s1;
        next_rst_s1 = reset_pin_in;
        next_rst_s2 = rst_s1;
        next_dbg_s1 = debug_line_in;
        next_dbg_s2 = dbg_s1;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            // pins idle high; zeros here would raise a false interrupt request
            s1 <= '1;
            s2 <= '1;
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
            dbg_s1 <= 1'b0;
            dbg_s2 <= 1'b0;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            rst_s1 <= next_rst_s1;
            rst_s2 <= next_rst_s2;
            dbg_s1 <= next_dbg_s1;
            dbg_s2 <= next_dbg_s2;
        end
    end

    // reset pin, mode capture, clock source, port E bit7 pull-up
    always_comb begin
        next_rst_prev = rst_s2;
        next_chip_rst_n = rst_s2 & ~rst_drive;
        next_rst_drive = int_reset_req;
        next_mode = mode_capture_bit;
        if (rst_s2 && !rst_prev) begin
            next_mode = dbg_s2;
        end
        // oscillator only after software selects it; any reset falls back
        next_osc = chip_reset_n ? (clk_source_osc | osc_select) : CLK_INTERNAL;
        next_pullup = ~chip_reset_n | port_e_bit7_pullup_req;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rst_prev <= 1'b0;
            chip_reset_n <= 1'b0;
            rst_drive <= 1'b0;
            mode_capture_bit <= MODE_RESET;
            clk_source_osc <= CLK_INTERNAL;
            port_e_pullup_en <= 1'b1;
        end else begin
            rst_prev <= next_rst_prev;
            chip_reset_n <= next_chip_rst_n;
            rst_drive <= next_rst_drive;
            mode_capture_bit <= next_mode;
            clk_source_osc <= next_osc;
            port_e_pullup_en <= next_pullup;
        end
    end

    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = rst_drive;
    assign bdm_active = (mode_capture_bit != MODE_NORMAL);
    assign debug_line_out = 1'b0;
    // driven low only, and never while the pin is a mode strap
    assign debug_line_oe = bdm_drive_low & chip_reset_n;
    assign debug_pullup_en = 1'b1;

    // bus clock divider; the doubled clock is exact only for prescale one
    always_comb begin
        next_dbl_clk = ~dbl_clk;
        if (cnt >= bus_clk_prescale) begin
            next_cnt = '0;
            next_bus_clk = ~bus_clk;
        end else begin
            next_cnt = cnt + PW'(1);
            next_bus_clk = bus_clk;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cnt <= '0;
            bus_clk <= 1'b0;
            dbl_clk <= 1'b0;
        end else begin
            cnt <= next_cnt;
            bus_clk <= next_bus_clk;
            dbl_clk <= next_dbl_clk;
        end
    end

    assign bus_clock_out = bus_clk;
    assign double_bus_clock_out = dbl_clk;

    // peripheral override selection
    always_comb begin
        p_en = '0;
        p_out = '0;
        p_oe = '0;
        p_en[OFF_E+E_DBLCLK] = dbl_clk_en;
        p_out[OFF_E+E_DBLCLK] = dbl_clk;
        p_oe[OFF_E+E_DBLCLK] = 1'b1;
        p_en[OFF_E+E_BUSCLK] = bus_clk_en;
        p_out[OFF_E+E_BUSCLK] = bus_clk;
        p_oe[OFF_E+E_BUSCLK] = 1'b1;
        // interrupt pins are forced to inputs whatever the port says
        p_en[OFF_E+E_IRQ] = 1'b1;
        p_en[OFF_E+E_NMI] = 1'b1;
        if (spi_en) begin
            p_en[OFF_M+M_SCK] = 1'b1;
            p_out[OFF_M+M_SCK] = spi_sck_out;
            p_oe[OFF_M+M_SCK] = spi_master;
            p_en[OFF_M+M_MOSI] = 1'b1;
            p_out[OFF_M+M_MOSI] = spi_mosi_out;
            p_oe[OFF_M+M_MOSI] = spi_master;
            p_en[OFF_M+M_MISO] = 1'b1;
            p_out[OFF_M+M_MISO] = spi_miso_out;
            p_oe[OFF_M+M_MISO] = ~spi_master;
            p_en[OFF_M+M_SS] = 1'b1;
            p_out[OFF_M+M_SS] = spi_ss_out;
            p_oe[OFF_M+M_SS] = spi_master & spi_ss_out_en;
        end
        if (can_en) begin
            p_en[OFF_M+M_CANTX] = 1'b1;
            p_out[OFF_M+M_CANTX] = can_tx_pin;
            p_oe[OFF_M+M_CANTX] = 1'b1;
            p_en[OFF_M+M_CANRX] = 1'b1;
        end
        if (serial_en) begin
            p_en[OFF_S+S_TX] = 1'b1;
            p_out[OFF_S+S_TX] = serial_tx;
            p_oe[OFF_S+S_TX] = 1'b1;
            p_en[OFF_S+S_RX] = 1'b1;
        end
        for (int i = 0; i < NPWM; i++) begin
            if (pwm_p_en[i]) begin
                p_en[OFF_P+i] = 1'b1;
                p_out[OFF_P+i] = pwm_out[i];
                p_oe[OFF_P+i] = 1'b1;
            end
        end
        for (int i = 0; i < NTIM; i++) begin
            case (pfm_tsel_e'(t_sel[2*i +: 2]))
                TSEL_TIMER: begin
                    p_en[OFF_T+i] = 1'b1;
                    p_out[OFF_T+i] = timer_out[i];
                    p_oe[OFF_T+i] = timer_oe[i];
                end
                TSEL_PWM: begin
                    // pins without a modulator output stay general purpose
                    p_en[OFF_T+i] = T_PWM_MASK[i];
                    p_out[OFF_T+i] = pwm_out[i % NPWM];
                    p_oe[OFF_T+i] = 1'b1;
                end
                TSEL_API: begin
                    p_en[OFF_T+i] = (i == T_API);
                    p_out[OFF_T+i] = periodic_int_ext_clock;
                    p_oe[OFF_T+i] = 1'b1;
                end
                default: begin
                    p_en[OFF_T+i] = 1'b0;
                end
            endcase
        end
    end

    for (genvar g = 0; g < NPIN; g++) begin : g_pin
        // pins float as inputs while the chip is held in reset
        assign next_pin_out[g] = p_en[g] ? p_out[g] : gpio_out_flat[g];
        assign next_pin_oe[g] = chip_reset_n & (p_en[g] ? p_oe[g] : gpio_oe_flat[g]);
    end

    // keypad edge detect and interrupt wakeup
    always_comb begin
        next_kj_prev = s2[OFF_J +: NP8];
        next_kp_prev = s2[OFF_P +: NP8];
        next_kw_j = keypad_j_enable & KEY_J_MASK & kj_prev & ~s2[OFF_J +: NP8];
        next_kw_p = keypad_p_enable & KEY_P_MASK & kp_prev & ~s2[OFF_P +: NP8];
        next_wake = (stop_active | wait_active) & (irq_request | nmi_request);
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_out <= '0;
            pin_oe <= '0;
            kj_prev <= '1;
            kp_prev <= '1;
            keypad_wake_j <= '0;
            keypad_wake_p <= '0;
            wake_pulse <= 1'b0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            kj_prev <= next_kj_prev;
            kp_prev <= next_kp_prev;
            keypad_wake_j <= next_kw_j;
            keypad_wake_p <= next_kw_p;
            wake_pulse <= next_wake;
        end
    end

    assign nmi_request = ~s2[OFF_E+E_NMI];
    assign irq_request = irq_enable & ~s2[OFF_E+E_IRQ];
    assign stop_enter_ok = stop_request & ~nmi_request;

    assign {t_pin_out, s_pin_out, p_pin_out, m_pin_out, j_pin_out, e_pin_out, ad_pin_out} = pin_out;
    assign {t_pin_oe, s_pin_oe, p_pin_oe, m_pin_oe, j_pin_oe, e_pin_oe, ad_pin_oe} = pin_oe;
    assign {t_gpio_in, s_gpio_in, p_gpio_in, m_gpio_in, j_gpio_in, e_gpio_in, ad_gpio_in} = s2;
    // analog path is a plain route; the converter does its own sampling
    assign converter_analog_inputs = ad_pin_in;
    assign spi_sck_in = s2[OFF_M+M_SCK];
    assign spi_mosi_in = s2[OFF_M+M_MOSI];
    assign spi_miso_in = s2[OFF_M+M_MISO];
    assign spi_ss_in = s2[OFF_M+M_SS];
    assign can_rx_pin = s2[OFF_M+M_CANRX];
    assign serial_rx = s2[OFF_S+S_RX];
    assign timer_in = s2[OFF_T +: NTIM];

    sequence s_reset_release;
        rst_s2 && !rst_prev;
    endsequence
    sequence s_nmi_low3;
        (!e_pin_in[E_NMI])[*3];
    endsequence

    a_reset_drive_low: assert property (int_reset_req |=> reset_pin_oe && !reset_pin_out)
        else $error("reset pin not driven low after internal reset");
    a_mode_capture: assert property (s_reset_release |=> mode_capture_bit == $past(dbg_s2))
        else $error("mode bit not captured at reset release");
    a_debug_quiet_reset: assert property (!chip_reset_n |-> !debug_line_oe)
        else $error("debug line driven during reset");
    a_clk_internal: assert property (!chip_reset_n |=> clk_source_osc == CLK_INTERNAL)
        else $error("clock source not internal after reset");
    a_nmi_level: assert property (s_nmi_low3 |-> nmi_request)
        else $error("nonmaskable request missing after pin low");
    a_stop_refused: assert property (nmi_request |-> !stop_enter_ok)
        else $error("stop allowed while nonmaskable pin low");
    a_wake_stop: assert property (s_nmi_low3 ##0 stop_active |=> wake_pulse)
        else $error("no wakeup from stop on nonmaskable pin");
    a_input_only: assert property (!e_pin_oe[E_IRQ] && !e_pin_oe[E_NMI])
        else $error("interrupt pin driven as output");
    a_pe7_pullup: assert property (!chip_reset_n |=> port_e_pullup_en)
        else $error("port E bit7 pull-up off during reset");
    a_mosi_override: assert property (chip_reset_n && spi_en && spi_master
        |=> m_pin_oe[M_MOSI] && m_pin_out[M_MOSI] == $past(spi_mosi_out))
        else $error("master MOSI not driven on port M bit4");
    a_irq_sync: assert property (irq_request |-> $past(e_pin_in[E_IRQ], 2) == 1'b0)
        else $error("maskable request without two-stage delay");
endmodule

/* verification/pfm_board.sv */
/*
 * pfm_board: board side of the pin block; reset switch, debug host, pull-ups.
 * assumes: the bench drives the switch and host; both lines are pulled high.
 */
`timescale 1ns/100ps
module pfm_board (
    input wire logic ext_rst_low,
    input wire logic host_low,
    input wire logic reset_pin_oe,
    input wire logic reset_pin_out,
    input wire logic debug_line_oe,
    input wire logic debug_line_out,
    output logic reset_pin_in,
    output logic debug_line_in
);
    // parties only pull low; a released line returns high through its pull-up
    assign reset_pin_in = ~(ext_rst_low | (reset_pin_oe & ~reset_pin_out));
    assign debug_line_in = ~(host_low | (debug_line_oe & ~debug_line_out));
endmodule

/* verification/pfm_pin_mux_tb.sv */
/*
 * pfm_pin_mux_tb: self-checking bench for the pin function block.
 * assumes: pfm_pkg and pfm_pin_mux compiled first; pfm_board models the board.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH at %0t got %h exp %h", $time, g, e); end end
module pfm_pin_mux_tb;
    import pfm_pkg::*;
    logic ref_clk = 1'b0, nrst = 1'b0, ext_rst_low, host_low, last;
    logic reset_pin_in, reset_pin_out, reset_pin_oe, int_reset_req, chip_reset_n;
    logic debug_line_in, debug_line_out, debug_line_oe, debug_pullup_en, bdm_drive_low;
    logic mode_capture_bit, bdm_active, osc_select, clk_source_osc, port_e_bit7_pullup_req;
    logic port_e_pullup_en, bus_clk_en, dbl_clk_en, bus_clock_out, double_bus_clock_out;
    logic irq_enable, stop_request, stop_active, wait_active, irq_request, nmi_request;
    logic stop_enter_ok, wake_pulse, spi_en, spi_master, spi_ss_out_en, spi_sck_out;
    logic spi_mosi_out, spi_miso_out, spi_ss_out, spi_sck_in, spi_mosi_in, spi_miso_in;
    logic spi_ss_in, can_en, can_tx_pin, can_rx_pin, serial_en, serial_tx, serial_rx;
    logic periodic_int_ext_clock;
    logic [3:0] bus_clk_prescale;
    logic [NAD-1:0] ad_pin_in, ad_pin_out, ad_pin_oe, ad_gpio_out, ad_gpio_oe, ad_gpio_in;
    logic [NAD-1:0] converter_analog_inputs;
    logic [7:0] e_pin_in, e_pin_out, e_pin_oe, e_gpio_out, e_gpio_oe, e_gpio_in;
    logic [7:0] j_pin_in, j_pin_out, j_pin_oe, j_gpio_out, j_gpio_oe, j_gpio_in;
    logic [7:0] m_pin_in, m_pin_out, m_pin_oe, m_gpio_out, m_gpio_oe, m_gpio_in;
    logic [7:0] p_pin_in, p_pin_out, p_pin_oe, p_gpio_out, p_gpio_oe, p_gpio_in;
    logic [7:0] t_pin_in, t_pin_out, t_pin_oe, t_gpio_out, t_gpio_oe, t_gpio_in;
    logic [NS-1:0] s_pin_in, s_pin_out, s_pin_oe, s_gpio_out, s_gpio_oe, s_gpio_in;
    logic [7:0] keypad_j_enable, keypad_p_enable, keypad_wake_j, keypad_wake_p, kacc_j, kacc_p;
    logic [7:0] timer_out, timer_oe, timer_in;
    logic [5:0] pwm_p_en, pwm_out;
    logic [15:0] t_sel;
    int fail_count = 0, total_checks = 0, cycles = 0, i, flips;

    pfm_pin_mux #(.PW(4)) uut (.*);
    pfm_board board (.*);

    always #50 ref_clk = ~ref_clk;

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // the whole run is under a hundred cycles; this only catches a hang
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            results();
        end
    end

    task automatic step;
        @(posedge ref_clk);
    endtask

    // settle on the falling edge so registered and synced outputs have landed
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    initial begin
        {ext_rst_low, host_low, int_reset_req, bdm_drive_low} = '0;
        {osc_select, port_e_bit7_pullup_req} = '0;
        {bus_clk_en, dbl_clk_en, bus_clk_prescale, irq_enable, stop_request} = '0;
        {stop_active, wait_active, spi_en, spi_master, spi_ss_out_en, spi_sck_out} = '0;
        {spi_mosi_out, spi_miso_out, spi_ss_out, can_en, can_tx_pin, serial_en, serial_tx} = '0;
        {periodic_int_ext_clock, ad_gpio_out, ad_gpio_oe, e_gpio_out, j_gpio_out} = '0;
        {j_gpio_oe, m_gpio_out, m_gpio_oe, p_gpio_out, p_gpio_oe, s_gpio_out, s_gpio_oe} = '0;
        {t_gpio_out, t_gpio_oe, keypad_j_enable, keypad_p_enable, pwm_p_en, pwm_out} = '0;
        {t_sel, timer_out, timer_oe, ad_pin_in, m_pin_in, s_pin_in, t_pin_in} = '0;
        {e_pin_in, j_pin_in, p_pin_in, e_gpio_oe} = '1;
        wt(4);
        `CHK({port_e_pullup_en, e_pin_oe}, 9'h100)
        step();
        nrst <= 1'b1;
        wt(5);
        `CHK({mode_capture_bit, bdm_active}, {MODE_NORMAL, 1'b0})
        `CHK({clk_source_osc, port_e_pullup_en}, {CLK_INTERNAL, 1'b0})
        `CHK(e_pin_oe, 8'hfc)
        step();
        ext_rst_low <= 1'b1;
        host_low <= 1'b1;
        wt(4);
        `CHK({chip_reset_n, port_e_pullup_en}, 2'b01)
        step();
        ext_rst_low <= 1'b0;
        wt(5);
        `CHK({mode_capture_bit, bdm_active}, 2'b01)
        step();
        host_low <= 1'b0;
        bdm_drive_low <= 1'b1;
        wt(1);
        `CHK({debug_line_oe, debug_line_out, debug_line_in, debug_pullup_en}, 4'h9)
        step();
        bdm_drive_low <= 1'b0;
        osc_select <= 1'b1;
        step();
        osc_select <= 1'b0;
        wt(1);
        `CHK(clk_source_osc, 1'b1)
        step();
        int_reset_req <= 1'b1;
        wt(6);
        `CHK({reset_pin_oe, reset_pin_out, reset_pin_in, chip_reset_n}, 4'h8)
        `CHK(clk_source_osc, CLK_INTERNAL)
        step();
        int_reset_req <= 1'b0;
        wt(6);
        `CHK({reset_pin_oe, chip_reset_n, mode_capture_bit}, 3'b011)
        step();
        stop_request <= 1'b1;
        stop_active <= 1'b1;
        wt(2);
        `CHK({nmi_request, stop_enter_ok, wake_pulse}, 3'b010)
        step();
        e_pin_in <= 8'hfe;
        wt(4);
        `CHK({nmi_request, stop_enter_ok, wake_pulse}, 3'b101)
        step();
        e_pin_in <= 8'hfd;
        irq_enable <= 1'b1;
        stop_active <= 1'b0;
        wait_active <= 1'b1;
        wt(4);
        `CHK({irq_request, nmi_request, stop_enter_ok, wake_pulse}, 4'hb)
        `CHK({e_gpio_in, e_pin_oe[1:0]}, 10'h3f4)
        step();
        e_pin_in <= 8'hff;
        wait_active <= 1'b0;
        ad_gpio_oe <= 10'h3ff;
        ad_gpio_out <= 10'h155;
        ad_pin_in <= 10'h2a3;
        m_gpio_oe <= 8'hff;
        m_pin_in <= 8'h15;
        {spi_en, spi_master, spi_ss_out_en, can_en, can_tx_pin, serial_en, serial_tx} <= '1;
        {spi_sck_out, spi_mosi_out, spi_ss_out, spi_miso_out} <= 4'hf;
        s_gpio_oe <= 4'hf;
        s_pin_in <= 4'h1;
        {pwm_p_en, pwm_out, p_gpio_oe, p_gpio_out} <= {6'h3f, 6'h1a, 8'hff, 8'h80};
        {t_sel, t_gpio_oe, timer_out, timer_oe} <= {16'h0e01, 8'h0e, 8'h01, 8'h01};
        periodic_int_ext_clock <= 1'b1;
        t_pin_in <= 8'h5a;
        wt(3);
        `CHK(converter_analog_inputs, 10'h2a3)
        `CHK({ad_pin_out, ad_pin_oe, ad_gpio_in}, {10'h155, 10'h3ff, 10'h2a3})
        `CHK({m_pin_oe, m_pin_out & 8'hfa}, 16'hfa3a)
        `CHK({spi_sck_in, spi_ss_in, timer_in, j_gpio_in}, 18'h05aff)
        `CHK({spi_miso_in, can_rx_pin, serial_rx}, 3'b111)
        `CHK({s_pin_oe, s_pin_out}, 8'he2)
        `CHK({p_pin_oe, p_pin_out}, 16'hff9a)
        `CHK({t_pin_oe, t_pin_out}, 16'h3f31)
        step();
        spi_master <= 1'b0;
        pwm_p_en <= 6'h00;
        wt(3);
        `CHK({m_pin_oe, m_pin_out & 8'hc6, spi_mosi_in}, 17'h18c0d)
        `CHK(p_pin_out, 8'h80)
        step();
        keypad_j_enable <= 8'hff;
        keypad_p_enable <= 8'hff;
        {kacc_j, kacc_p} = '0;
        step();
        j_pin_in <= 8'h00;
        p_pin_in <= 8'h00;
        repeat (6) begin
            wt(1);
            kacc_j = kacc_j | keypad_wake_j;
            kacc_p = kacc_p | keypad_wake_p;
        end
        `CHK({kacc_j, kacc_p, keypad_wake_j}, {KEY_J_MASK, KEY_P_MASK, 8'h00})
        for (i = 0; i < 2; i++) begin
            step();
            {bus_clk_en, dbl_clk_en} <= 2'b11;
            bus_clk_prescale <= i ? 4'h2 : 4'h0;
            wt(2);
            flips = 0;
            last = bus_clock_out;
            repeat (6) begin
                wt(1);
                flips += int'(bus_clock_out !== last);
                last = bus_clock_out;
            end
            `CHK(flips, i ? 2 : 6)
        end
        // the registered pin lags the doubled clock by one cycle, so they always differ
        `CHK({e_pin_oe[7], e_pin_out[7] ^ double_bus_clock_out}, 2'b11)
        results();
    end
endmodule
